// ---- logic/eipu_top.sv ----
// External pin interrupt unit: pin sensing, flags, vectors and registers.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module eipu_top
    import eipu_pkg::*;
#(
    parameter int unsigned NUM_GROUPS = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register bus
    input wire eipu_axil_req_t axi_req_i,
    output eipu_axil_rsp_t axi_rsp_o,
    // Pins
    input wire logic dedicated_irq_pin_i,
    input wire logic [PC_WIDTH-1:0] pin_change_inputs_i,
    // Core side
    input wire logic core_global_ie_i,
    input wire logic io_clk_run_i,
    input wire logic irq_ack_i,
    input wire logic [2:0] irq_ack_vec_i,
    output logic [VEC_COUNT-1:0] irq_req_o,
    output logic wake_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_GROUPS != 2 && NUM_GROUPS != GROUPS_MAX) begin : g_bad
        $error("NUM_GROUPS must be 2 or 4");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ded_s1;
        logic ded_s2;
        logic ded_prev;
        logic [PC_WIDTH-1:0] pc_s1;
        logic [PC_WIDTH-1:0] pc_s2;
        logic [PC_WIDTH-1:0] pc_prev;
        eipu_sense_t sense;
        logic [7:0] enable;
        logic [7:0] flags;
        logic [GROUPS_MAX-1:0][7:0] pmask;
        logic aw_full;
        logic [AXI_AW-1:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } eipu_state_t;

    eipu_state_t st;
    eipu_state_t next_st;

    // Groups that this variant builds; the others never flag or request.
    localparam logic [7:0] PRESENT =
        (NUM_GROUPS == GROUPS_MAX) ? SRC_BITS : 8'h31;

    // ------------------------------------------------------------------
    // Pin-change detection per group
    // ------------------------------------------------------------------
    logic [31:0] pc_now;
    logic [31:0] pc_old;
    logic [31:0] pc_raw;
    logic [GROUPS_MAX-1:0] grp_change;
    logic [GROUPS_MAX-1:0] grp_wake;

    assign pc_now = {1'b0, st.pc_s2};
    assign pc_old = {1'b0, st.pc_prev};
    assign pc_raw = {1'b0, pin_change_inputs_i};

    for (genvar g = 0; g < GROUPS_MAX; g++) begin : g_grp
        // Only unmasked inputs of a group can raise its change.
        assign grp_change[g] = |((pc_now[8*g +: 8] ^ pc_old[8*g +: 8])
            & st.pmask[g]); // see [R8] see [R9]
        // Raw pin against its last sampled value needs no clock to wake.
        assign grp_wake[g] = |((pc_raw[8*g +: 8] ^ pc_now[8*g +: 8])
            & st.pmask[g] & {8{st.enable[BIT_GROUP_LO+g]}}); // see [R6]
    end

    // ------------------------------------------------------------------
    // Dedicated pin sensing
    // ------------------------------------------------------------------
    logic ded_fall;
    logic ded_rise;
    logic ded_edge_hit;
    logic ded_level_req;
    logic [7:0] hw_set;
    logic [7:0] ack_clr;

    // The synchronised sample feeds edge detection; no edge is seen while
    // the I/O clock is stopped in deeper sleep.
    assign ded_fall = st.ded_prev && !st.ded_s2; // see [R4]
    assign ded_rise = !st.ded_prev && st.ded_s2;

    always_comb begin
        ded_edge_hit = 1'b0;
        unique case (st.sense)
            SENSE_LOW: ded_edge_hit = 1'b0;
            SENSE_ANY: ded_edge_hit = ded_fall || ded_rise; // see [R1]
            SENSE_FALL: ded_edge_hit = ded_fall; // see [R1] see [R3]
            SENSE_RISE: ded_edge_hit = ded_rise; // see [R1]
        endcase
        ded_edge_hit = ded_edge_hit && io_clk_run_i; // see [R18]
    end

    // A low level that is gone before it is sampled never requests, so a
    // wake from a short level leaves no interrupt behind.
    assign ded_level_req = (st.sense == SENSE_LOW) && !st.ded_s2; // see [R17]

    always_comb begin
        hw_set = 8'h00;
        hw_set[BIT_DED] = ded_edge_hit;
        hw_set[BIT_GROUP_LO +: GROUPS_MAX] = grp_change;
        hw_set = hw_set & PRESENT;
    end

    // Vector entry clears the flag of the vector being served.
    always_comb begin
        ack_clr = 8'h00;
        if (irq_ack_i) begin
            if (irq_ack_vec_i == 3'h0) begin
                ack_clr[BIT_DED] = 1'b1; // see [R13]
            end else if (irq_ack_vec_i <= 3'h4) begin
                ack_clr[BIT_GROUP_LO + 32'(irq_ack_vec_i) - 1] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    logic do_write;
    logic wr_lane;
    logic [9:0] wr_idx;
    logic [9:0] rd_idx;
    logic rd_take;
    logic [31:0] rd_val;
    logic rd_hit;
    logic wr_hit;
    logic [7:0] wr_byte;
    logic [7:0] sw_clr;

    assign do_write = st.aw_full && st.w_full && !st.bvalid;
    assign wr_idx = st.awaddr[AXI_AW-1:2];
    assign rd_idx = axi_req_i.araddr[AXI_AW-1:2];
    assign wr_lane = st.wstrb[0];
    assign wr_byte = st.wdata[7:0];
    assign rd_take = axi_req_i.arvalid && !st.rvalid;

    always_comb begin
        wr_hit = 1'b1;
        unique case (wr_idx)
            IDX_FLAGS, IDX_ENABLE, IDX_SENSE, IDX_PMASK0, IDX_PMASK1: ;
            IDX_PMASK2, IDX_PMASK3: wr_hit = (NUM_GROUPS == GROUPS_MAX);
            default: wr_hit = 1'b0;
        endcase
    end

    assign sw_clr = (do_write && wr_lane && wr_idx == IDX_FLAGS)
        ? (wr_byte & SRC_BITS) : 8'h00; // see [R13]

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (rd_idx)
            IDX_FLAGS: rd_val[7:0] = st.flags & PRESENT; // see [R19]
            IDX_ENABLE: rd_val[7:0] = st.enable;
            IDX_SENSE: rd_val[1:0] = st.sense;
            IDX_PMASK0: rd_val[7:0] = st.pmask[0];
            IDX_PMASK1: rd_val[7:0] = st.pmask[1];
            IDX_PMASK2: rd_val[7:0] = st.pmask[2];
            IDX_PMASK3: rd_val[7:0] = st.pmask[3];
            default: rd_hit = 1'b0;
        endcase
        if ((rd_idx == IDX_PMASK2 || rd_idx == IDX_PMASK3)
            && NUM_GROUPS != GROUPS_MAX) begin
            rd_hit = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Pins are sampled even when driven as outputs by the port logic.
        next_st.ded_s1 = dedicated_irq_pin_i; // see [R7]
        next_st.ded_s2 = st.ded_s1;
        next_st.ded_prev = st.ded_s2;
        next_st.pc_s1 = pin_change_inputs_i;
        next_st.pc_s2 = st.pc_s1;
        next_st.pc_prev = st.pc_s2;

        if (axi_req_i.awvalid && !st.aw_full && !st.bvalid) begin
            next_st.aw_full = 1'b1;
            next_st.awaddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && !st.w_full && !st.bvalid) begin
            next_st.w_full = 1'b1;
            next_st.wdata = axi_req_i.wdata;
            next_st.wstrb = axi_req_i.wstrb;
        end
        if (do_write) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (wr_lane && wr_hit) begin
                unique case (wr_idx)
                    IDX_ENABLE: next_st.enable = wr_byte & PRESENT; // see [R10]
                    IDX_SENSE: next_st.sense = eipu_sense_t'(wr_byte[1:0]);
                    IDX_PMASK0: next_st.pmask[0] = wr_byte; // see [R20]
                    IDX_PMASK1: next_st.pmask[1] = wr_byte;
                    IDX_PMASK2: next_st.pmask[2] = wr_byte;
                    IDX_PMASK3: next_st.pmask[3] = {1'b0, wr_byte[6:0]};
                    default: ;
                endcase
            end
        end else if (st.bvalid && axi_req_i.bready) begin
            next_st.bvalid = 1'b0;
        end

        if (rd_take) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_val;
            next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (st.rvalid && axi_req_i.rready) begin
            next_st.rvalid = 1'b0;
        end

        // A fresh event outlives a clear that lands in the same cycle.
        next_st.flags = ((st.flags & ~(sw_clr | ack_clr)) | hw_set)
            & PRESENT; // see [R21] see [R12]
        if (next_st.sense == SENSE_LOW) begin
            next_st.flags[BIT_DED] = 1'b0; // see [R14]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.sense <= eipu_sense_t'(RST_SENSE);
            st.enable <= RST_ENABLE;
            st.flags <= RST_FLAGS;
            st.pmask <= {GROUPS_MAX{RST_PMASK}};
            st.ded_s1 <= 1'b1;
            st.ded_s2 <= 1'b1;
            st.ded_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic [7:0] live;
    logic ded_pending;

    // The driver must hold a low level until the running instruction is
    // done; the core samples this request only at instruction ends.
    assign ded_pending = (st.sense == SENSE_LOW) ? ded_level_req
        : st.flags[BIT_DED]; // see [R2] see [R16]
    assign live = st.enable & PRESENT & {8{core_global_ie_i}};

    // Each source asserts its own vector line.
    assign irq_req_o[0] = ded_pending && live[BIT_DED]; // see [R11] see [R15]
    for (genvar v = 1; v < VEC_COUNT; v++) begin : g_vec
        assign irq_req_o[v] = st.flags[BIT_GROUP_LO+v-1]
            && live[BIT_GROUP_LO+v-1]; // see [R15]
    end

    // The raw pin is looked at directly so a stopped clock still wakes.
    assign wake_o = (|grp_wake) || ((st.sense == SENSE_LOW)
        && !dedicated_irq_pin_i && st.enable[BIT_DED]); // see [R5]

    assign axi_rsp_o.awready = !st.aw_full && !st.bvalid;
    assign axi_rsp_o.wready = !st.w_full && !st.bvalid;
    assign axi_rsp_o.bvalid = st.bvalid;
    assign axi_rsp_o.bresp = st.bresp;
    assign axi_rsp_o.arready = !st.rvalid;
    assign axi_rsp_o.rvalid = st.rvalid;
    assign axi_rsp_o.rdata = st.rdata;
    assign axi_rsp_o.rresp = st.rresp;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic no_clr0;
    assign no_clr0 = !irq_ack_i && !(do_write && wr_idx == IDX_FLAGS);

    sequence s_fall_seen;
        st.sense == SENSE_FALL && io_clk_run_i && st.ded_prev
            && !st.ded_s2;
    endsequence
    sequence s_flag_kept;
        (st.sense == SENSE_FALL && no_clr0)[*2];
    endsequence

    a_fall_flags: assert property ( // see [R3]
        s_fall_seen ##0 s_flag_kept |=> st.flags[BIT_DED])
        else $error("falling edge did not hold the pin flag");
    a_level_request: assert property ( // see [R2]
        st.sense == SENSE_LOW && !st.ded_s2 && st.enable[BIT_DED]
        && core_global_ie_i |-> irq_req_o[0])
        else $error("low level did not request");
    a_level_flag_zero: assert property ( // see [R14]
        st.sense == SENSE_LOW |-> !st.flags[BIT_DED])
        else $error("pin flag set in level mode");
    a_pin_two_stages: assert property ( // see [R4]
        $fell(dedicated_irq_pin_i) ##1 !dedicated_irq_pin_i
        |=> !st.ded_s2)
        else $error("pin sample not two stages deep");
    a_group_flag_set: assert property ( // see [R8]
        grp_change[0] |=> st.flags[BIT_GROUP_LO])
        else $error("group zero change lost");
    a_req_gated: assert property ( // see [R15]
        irq_req_o[1] |-> core_global_ie_i && st.enable[BIT_GROUP_LO]
        && st.flags[BIT_GROUP_LO])
        else $error("group request without flag and enables");
    a_ack_clears: assert property ( // see [R13]
        irq_ack_i && irq_ack_vec_i == 3'h1 && !grp_change[0]
        |=> !st.flags[BIT_GROUP_LO])
        else $error("vector entry did not clear group flag");
    a_set_beats_clr: assert property ( // see [R21]
        grp_change[1] && (sw_clr[BIT_GROUP_LO+1] || ack_clr[BIT_GROUP_LO+1])
        |=> st.flags[BIT_GROUP_LO+1])
        else $error("clear beat a same-cycle set");
    a_absent_zero: assert property ( // see [R19]
        NUM_GROUPS != GROUPS_MAX |-> st.flags[7:6] == 2'b00)
        else $error("absent group flag set");
    a_no_edge_asleep: assert property ( // see [R18]
        !io_clk_run_i && st.sense != SENSE_LOW && no_clr0
        |=> st.flags[BIT_DED] == $past(st.flags[BIT_DED]))
        else $error("edge flagged without I/O clock");
    a_wake_low: assert property ( // see [R5]
        st.sense == SENSE_LOW && st.enable[BIT_DED] && !dedicated_irq_pin_i
        |-> wake_o)
        else $error("low level gave no wake");

endmodule
`default_nettype wire

// ---- logic/eipu_pkg.sv ----
// Constants, types and bus carriers for the external pin interrupt unit.
// Functional notes
// [R1] Sense bits pick low, change, fall, rise.
// [R2] Level mode requests while pin stays low.
// [R3] Edge pulses over one clock are caught.
// [R4] Pin sampled first; edges need I/O clock.
// [R5] Low level detected clocklessly for wake-up.
// [R6] Pin changes detected clocklessly for wake-up.
// [R7] Pins driven as outputs still interrupt.
// [R8] Four pin-change groups, any enabled toggle.
// [R9] Per-input mask bit gates group change.
// [R10] Enables at bits 7:4 and 0, with global.
// [R11] Each source has its own vector.
// [R12] Group flags bits 7:4, pin flag 0.
// [R13] Entry or write-one clears a flag.
// [R14] Level mode keeps the pin flag cleared.
// [R15] Vector taken on flag, enable and global.
// [R16] Driver holds low level for one instruction.
// [R17] Vanished wake level gives no interrupt.
// [R18] Edge sensing stops without I/O clock.
// [R19] Missing groups read zero flags.
// [R20] Per-group 8-bit input masks, reset zero. The code holds bit 7 of the group 3 mask at zero.
// [R21] Hardware set beats same-cycle clear.
package eipu_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned PC_WIDTH = 31;
    localparam int unsigned GROUPS_MAX = 4;
    localparam int unsigned VEC_COUNT = 5;
    localparam int unsigned AXI_AW = 12;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_FLAGS = 10'h01C;
    localparam logic [9:0] IDX_ENABLE = 10'h01D;
    localparam logic [9:0] IDX_SENSE = 10'h069;
    localparam logic [9:0] IDX_PMASK0 = 10'h06B;
    localparam logic [9:0] IDX_PMASK1 = 10'h06C;
    localparam logic [9:0] IDX_PMASK2 = 10'h06D;
    localparam logic [9:0] IDX_PMASK3 = 10'h06E;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned BIT_DED = 0;
    localparam int unsigned BIT_GROUP_LO = 4;
    localparam logic [7:0] SRC_BITS = 8'hF1;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [1:0] RST_SENSE = 2'h0;
    localparam logic [7:0] RST_PMASK = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } eipu_sense_t;

    // ------------------------------------------------------------------
    // AXI4-Lite carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } eipu_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } eipu_axil_rsp_t;

endpackage

// ---- tb/eipu_core_model.sv ----
// Behavioural core that enters the lowest pending interrupt vector.
`timescale 1ns/1ps
`default_nettype none
module eipu_core_model
    import eipu_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Unit side
    input wire logic [VEC_COUNT-1:0] irq_req_i,
    output logic irq_ack_o,
    output logic [2:0] irq_ack_vec_o,
    // Bench control
    input wire logic take_en_i,
    input wire logic [3:0] delay_i
);
    int wt;
    int gap;

    function automatic logic [2:0] lowest(input logic [VEC_COUNT-1:0] r);
        lowest = 3'h0;
        for (int i = VEC_COUNT - 1; i >= 0; i--) begin
            if (r[i]) begin
                lowest = 3'(i);
            end
        end
    endfunction

    // ------------
    // Vector entry
    // ------------
    // The gap after each entry lets the cleared flag drop its request.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_ack_o <= 1'h0;
            irq_ack_vec_o <= 3'h0;
            wt <= 0;
            gap <= 0;
        end else begin
            irq_ack_o <= 1'h0;
            if (gap != 0) begin
                gap <= gap - 1;
            end else if (take_en_i && (irq_req_i != '0)) begin
                if (wt < int'(delay_i)) begin
                    wt <= wt + 1;
                end else begin
                    irq_ack_o <= 1'h1;
                    irq_ack_vec_o <= lowest(irq_req_i);
                    wt <= 0;
                    gap <= 3;
                end
            end else begin
                wt <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the external pin interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import eipu_pkg::*;
;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    eipu_axil_req_t req = '0;
    eipu_axil_rsp_t rsp;
    logic ded_pin = 1'h1;
    logic [PC_WIDTH-1:0] pins = '0;
    logic gie = 1'h0;
    logic io_run = 1'h1;
    logic take_en = 1'h0;
    logic [3:0] delay = 4'h0;
    logic ack;
    logic [2:0] ack_vec;
    logic [VEC_COUNT-1:0] irq_req;
    logic wake;
    logic [9:0] exp_q[$];
    logic [2:0] vec_q[$];
    int miscompares = 0;
    int n_compared = 0;

    always #2.5 clk_i = ~clk_i;

    eipu_top #(.NUM_GROUPS(4)) i_eipu_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .axi_req_i(req), .axi_rsp_o(rsp),
        .dedicated_irq_pin_i(ded_pin), .pin_change_inputs_i(pins),
        .core_global_ie_i(gie), .io_clk_run_i(io_run), .irq_ack_i(ack),
        .irq_ack_vec_i(ack_vec), .irq_req_o(irq_req), .wake_o(wake));

    eipu_core_model i_eipu_core_model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req),
        .irq_ack_o(ack), .irq_ack_vec_o(ack_vec), .take_en_i(take_en),
        .delay_i(delay));

    // ----------------------
    // Checks and bus cycles
    // ----------------------
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic hang();
        miscompares++;
        $display("mismatch at %0t: wait ran out", $time);
        wrap_up();
    endtask

    // Ready is sampled at the falling edge, so the handshake at the
    // following rising edge is known without racing the design's flops.
    task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        int n;
        logic ha, hw, hb;
        exp_q.push_back({er, 8'h00});
        @(posedge clk_i);
        req.awvalid <= 1'h1;
        req.awaddr <= {idx, 2'h0};
        req.wvalid <= 1'h1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        req.bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk_i);
            ha = req.awvalid & rsp.awready;
            hw = req.wvalid & rsp.wready;
            hb = rsp.bvalid;
            @(posedge clk_i);
            if (ha) req.awvalid <= 1'h0;
            if (hw) req.wvalid <= 1'h0;
            if (hb) begin
                req.bready <= 1'h0;
                break;
            end
        end
        if (n == 40) hang();
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] ed,
                      input logic [1:0] er);
        int n;
        logic ha, hr;
        exp_q.push_back({er, ed});
        @(posedge clk_i);
        req.arvalid <= 1'h1;
        req.araddr <= {idx, 2'h0};
        req.rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk_i);
            ha = req.arvalid & rsp.arready;
            hr = rsp.rvalid;
            @(posedge clk_i);
            if (ha) req.arvalid <= 1'h0;
            if (hr) begin
                req.rready <= 1'h0;
                break;
            end
        end
        if (n == 40) hang();
    endtask

    task automatic tgl(input int k);
        @(posedge clk_i);
        pins[k] <= ~pins[k];
        repeat (6) @(posedge clk_i);
    endtask

    task automatic ded(input logic v);
        @(posedge clk_i);
        ded_pin <= v;
        repeat (6) @(posedge clk_i);
    endtask

    always @(negedge clk_i) begin
        if (rsp.bvalid && req.bready) begin
            chk({rsp.bresp, 8'h00}, exp_q.pop_front());
        end
        if (rsp.rvalid && req.rready) begin
            chk({rsp.rresp, rsp.rdata[7:0]}, exp_q.pop_front());
        end
        if (ack === 1'h1) begin
            chk({7'h00, ack_vec}, {7'h00, vec_q.pop_front()});
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        hang();
    end

    // ---------
    // Sequence
    // ---------
    initial begin
        int g, w, m, n;
        int bs[4];
        logic [7:0] e;
        n = $urandom(32'hF59B);
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'h1;
        rd(IDX_FLAGS, RST_FLAGS, RESP_OKAY);
        rd(IDX_ENABLE, RST_ENABLE, RESP_OKAY);
        rd(IDX_SENSE, 8'(RST_SENSE), RESP_OKAY);
        for (g = 0; g < 4; g++) rd(IDX_PMASK0 + 10'(g), RST_PMASK, RESP_OKAY);
        rd(10'h3FF, 8'h00, RESP_SLVERR);
        wr(10'h3FF, 8'h5A, RESP_SLVERR);
        wr(IDX_ENABLE, SRC_BITS, RESP_OKAY);
        rd(IDX_ENABLE, SRC_BITS, RESP_OKAY);
        for (g = 0; g < 4; g++) begin
            w = (g == 3) ? 7 : 8;
            bs[g] = 8 * g + $urandom_range(w - 1, 0);
            wr(IDX_PMASK0 + 10'(g), 8'(1 << (bs[g] % 8)), RESP_OKAY);
            tgl(8 * g + ((bs[g] % 8) + 1) % w);
            rd(IDX_FLAGS, 8'h00, RESP_OKAY);
            tgl(bs[g]);
            e = 8'(8'h10 << g);
            rd(IDX_FLAGS, e, RESP_OKAY);
            @(negedge clk_i);
            chk(10'(irq_req), 10'h000);
            wr(IDX_FLAGS, e, RESP_OKAY);
            rd(IDX_FLAGS, 8'h00, RESP_OKAY);
        end
        // A pin change that lands on the write-one clear must survive it.
        pins[bs[1]] <= ~pins[bs[1]];
        wr(IDX_FLAGS, 8'h20, RESP_OKAY);
        rd(IDX_FLAGS, 8'h20, RESP_OKAY);
        wr(IDX_FLAGS, 8'h20, RESP_OKAY);
        for (m = 1; m < 4; m++) begin
            wr(IDX_SENSE, 8'(m), RESP_OKAY);
            ded(1'h0);
            rd(IDX_FLAGS, (m != 3) ? 8'h01 : 8'h00, RESP_OKAY);
            wr(IDX_FLAGS, 8'h01, RESP_OKAY);
            ded(1'h1);
            rd(IDX_FLAGS, (m != 2) ? 8'h01 : 8'h00, RESP_OKAY);
            wr(IDX_FLAGS, 8'h01, RESP_OKAY);
        end
        io_run <= 1'h0;
        ded(1'h0);
        ded(1'h1);
        rd(IDX_FLAGS, 8'h00, RESP_OKAY);
        io_run <= 1'h1;
        wr(IDX_SENSE, 8'h00, RESP_OKAY);
        gie <= 1'h1;
        ded(1'h0); // held low for many cycles
        @(negedge clk_i);
        chk(10'(irq_req), 10'h001);
        chk({9'h000, wake}, 10'h001);
        rd(IDX_FLAGS, 8'h00, RESP_OKAY);
        gie <= 1'h0;
        @(negedge clk_i);
        chk(10'(irq_req), 10'h000);
        ded(1'h1);
        wr(IDX_SENSE, 8'h03, RESP_OKAY);
        ded(1'h0);
        ded(1'h1);
        tgl(bs[0]);
        tgl(bs[3]);
        rd(IDX_FLAGS, 8'h91, RESP_OKAY);
        vec_q.push_back(3'h0);
        vec_q.push_back(3'h1);
        vec_q.push_back(3'h4);
        delay <= 4'($urandom_range(5, 0));
        take_en <= 1'h1;
        gie <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(negedge clk_i);
            if (vec_q.size() == 0 && irq_req === 5'h00) break;
        end
        if (n == 200) hang();
        @(posedge clk_i);
        take_en <= 1'h0;
        gie <= 1'h0;
        rd(IDX_FLAGS, 8'h00, RESP_OKAY);
        repeat (4) @(posedge clk_i);
        chk(10'(exp_q.size() + vec_q.size()), 10'h000);
        wrap_up();
    end
endmodule
`default_nettype wire
